// ==== hub_port_pkg.sv ====
// Purpose: shared constants for the hub port control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   printed offsets are not all multiples of four, so byte address is four times the index
package hub_port_pkg;

  // register indices as printed, byte address is index times four
  localparam logic [15:0] IDX_HUB_PORT_COMMAND = 16'h1fc5;
  localparam logic [15:0] IDX_HUB_POWER_STATUS = 16'h1fc7;
  localparam logic [15:0] IDX_HUB_GLOBAL_STATE = 16'h1ffb;
  localparam logic [15:0] IDX_PORT2_STATUS     = 16'h1fa0;
  localparam logic [15:0] IDX_PORT3_STATUS     = 16'h1fa1;
  localparam logic [15:0] IDX_PORT1_STATUS     = 16'h1f9f;

  // reset values
  localparam logic [7:0] RST_HUB_PORT_COMMAND = 8'h00;
  localparam logic [7:0] RST_HUB_POWER_STATUS = 8'h00;
  localparam logic [7:0] RST_HUB_GLOBAL_STATE = 8'h00;

  // global state fields
  localparam int GS_SUSPEND = 4;
  localparam int GS_RESUME  = 3;
  localparam int GS_RWAKE   = 2;
  localparam int GS_CONFIG  = 1;
  localparam int GS_ADDR    = 0;

  // hub power status fields
  localparam int HS_OC_CHANGE = 3;
  localparam int HS_LP_CHANGE = 2;
  localparam int HS_OC_FLAG   = 1;
  localparam int HS_LP_LOST   = 0;
  localparam logic [7:0] HS_WMASK = 8'h0f;

  // port command layout
  localparam int CMD_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam logic [7:0] PC_WMASK = 8'h77;

  // port status fields
  localparam int PS_SLOW    = 6;
  localparam int PS_POWER   = 5;
  localparam int PS_RESET   = 4;
  localparam int PS_OC      = 3;
  localparam int PS_SUSP    = 2;
  localparam int PS_ENABLED = 1;
  localparam int PS_CONN    = 0;

  // port commands
  typedef enum logic [2:0] {
    CMD_DISABLE = 3'b000,
    CMD_ENABLE  = 3'b001,
    CMD_RESET   = 3'b010,
    CMD_SUSPEND = 3'b011,
    CMD_RESUME  = 3'b100
  } port_cmd_e;

  // port select codes
  localparam logic [2:0] SEL_PORT1 = 3'b001;
  localparam logic [2:0] SEL_PORT2 = 3'b010;
  localparam logic [2:0] SEL_PORT3 = 3'b011;

  // timing
  localparam int CLK_MHZ        = 100;
  localparam int RESUME_K_MS    = 20;
  localparam int RESUME_K_CYC   = RESUME_K_MS * 1000 * CLK_MHZ;
  localparam int PORT_RESET_MS  = 10;
  localparam int PORT_RESET_CYC = PORT_RESET_MS * 1000 * CLK_MHZ;
  localparam int EOP_CYC        = 2;
  localparam int TMR_W          = 32;

endpackage : hub_port_pkg

// ==== sync2.sv ====
// Purpose: two-flop synchroniser for pin-side levels
// Assumes: input asynchronous to pclk
// Notes:   first flop is read only by the second
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // two stages, constant under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync2

// ==== port_engine.sv ====
// Purpose: one external downstream port: enable, reset, suspend and resume sequencing
// Assumes: command pulse from the register block, synchronised pin levels
// Notes:   long waits are parameters so a simulation can shorten them
`timescale 1ns/10ps
module port_engine
  import hub_port_pkg::*;
#(
  parameter int RESUME_CYC = RESUME_K_CYC,
  parameter int RESET_CYC  = PORT_RESET_CYC
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // command
  input  wire logic       cmd_go,
  input  wire logic [2:0] cmd,
  // wakeup
  input  wire logic       wake_ok,
  input  wire logic       wake_evt,
  // state out
  output logic            enabled_q,
  output logic            suspended_q,
  output logic            resetting,
  output logic            drive_k,
  output logic            drive_se0,
  output logic            repeat_en,
  output logic            resume_busy
);
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_ON    = 3'b001,
    ST_RST   = 3'b010,
    ST_SUSP  = 3'b011,
    ST_K     = 3'b100,
    ST_EOP   = 3'b101
  } pstate_e;

  pstate_e          st_q;
  logic [TMR_W-1:0] tmr_q;

  // sequencer; any command but resume preempts a wait in progress, resume acts only from suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= ST_OFF;
      tmr_q <= '0;
    end else if (cmd_go) begin
      unique case (cmd)
        CMD_DISABLE: st_q <= ST_OFF;
        CMD_ENABLE:  st_q <= ST_ON;
        CMD_RESET: begin
          st_q  <= ST_RST;
          tmr_q <= TMR_W'(RESET_CYC - 1);
        end
        CMD_SUSPEND: st_q <= ST_SUSP;
        CMD_RESUME: begin
          if (st_q == ST_SUSP) begin
            st_q  <= ST_K;
            tmr_q <= TMR_W'(RESUME_CYC - 1);
          end
        end
        default: st_q <= st_q;
      endcase
    end else begin
      unique case (st_q)
        ST_RST: begin
          if (tmr_q == '0) st_q <= ST_ON;
          else tmr_q <= tmr_q - 1'b1;
        end
        ST_SUSP: begin
          // wakeup only while remote wake is permitted
          if (wake_ok && wake_evt) begin
            st_q  <= ST_K;
            tmr_q <= TMR_W'(RESUME_CYC - 1);
          end
        end
        ST_K: begin
          if (tmr_q == '0) begin
            st_q  <= ST_EOP;
            tmr_q <= TMR_W'(EOP_CYC - 1);
          end else tmr_q <= tmr_q - 1'b1;
        end
        ST_EOP: begin
          if (tmr_q == '0) st_q <= ST_ON;
          else tmr_q <= tmr_q - 1'b1;
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // decoded state
  always_comb begin
    enabled_q   = (st_q == ST_ON);
    suspended_q = (st_q == ST_SUSP) || (st_q == ST_K) || (st_q == ST_EOP);
    resetting   = (st_q == ST_RST);
    drive_k     = (st_q == ST_K);
    drive_se0   = (st_q == ST_RST) || (st_q == ST_EOP);
    repeat_en   = (st_q == ST_ON);
    resume_busy = (st_q == ST_K) || (st_q == ST_EOP);
  end
endmodule : port_engine

// ==== hub_port_control.sv ====
// Purpose: hub-level state and downstream port control with an APB register file
// Assumes: pin levels are asynchronous and pass sync2 before use
// Notes:   byte address of each register is four times its printed index
`timescale 1ns/10ps
module hub_port_control
  import hub_port_pkg::*;
#(
  parameter int RESUME_CYC = RESUME_K_CYC,
  parameter int RESET_CYC  = PORT_RESET_CYC
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // hub events from the upstream engine (same clock)
  input  wire logic        hub_suspended,
  input  wire logic        upstream_resume,
  input  wire logic        eof2_tick,
  // downstream pin levels, ports 2 and 3 (asynchronous)
  input  wire logic [1:0]  dev_connect,
  input  wire logic [1:0]  dev_low_speed,
  input  wire logic [1:0]  dev_j_to_k,
  // downstream drive, ports 2 and 3
  output logic      [1:0]  port_drive_k,
  output logic      [1:0]  port_drive_se0,
  output logic      [1:0]  port_repeat_en,
  // embedded function
  output logic             func_reset,
  output logic             func_respond_en,
  output logic             hub_addr_enable
);
  // access decode
  logic        wr_en;
  logic        rd_en;
  logic [15:0] idx;
  logic        hit;

  // registers
  logic [7:0] cmd_q;
  logic       cmd_go_q;
  logic [7:0] hps_q;
  logic       rwake_q;
  logic       config_q;
  logic       addr_q;
  logic       resume_ind_q;
  logic [1:0] power_q;
  logic [1:0] oc_q;
  logic [1:0] slow_q;
  logic [1:0] conn_q;
  logic [1:0] conn_prev_q;
  logic       p1_susp_q;
  logic [31:0] prdata_q;

  // synchronised pins
  logic [1:0] conn_s;
  logic [1:0] ls_s;
  logic [1:0] jk_s;

  // engine outputs
  logic [1:0] en_w;
  logic [1:0] susp_w;
  logic [1:0] rst_w;
  logic [1:0] busy_w;
  logic [1:0] go_w;

  // byte lane 0 written only when its strobe is set
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] msk,
                                       input logic lane);
    merge = lane ? ((old & ~msk) | (nw & msk)) : old;
  endfunction : merge

  // assemble a port status byte
  function automatic logic [7:0] pstat(input logic slow, input logic pwr, input logic rst, input logic oc,
                                       input logic sus, input logic en, input logic con);
    pstat = {1'b0, slow, pwr, rst, oc, sus, en, con};
  endfunction : pstat

  // apb decode; byte address is four times the index
  assign idx     = paddr[17:2];
  assign hit     = (idx == IDX_HUB_PORT_COMMAND) || (idx == IDX_HUB_POWER_STATUS) ||
                   (idx == IDX_HUB_GLOBAL_STATE) || (idx == IDX_PORT1_STATUS) ||
                   (idx == IDX_PORT2_STATUS) || (idx == IDX_PORT3_STATUS);
  assign wr_en   = psel && penable && pwrite && hit;
  assign rd_en   = psel && !penable && !pwrite; // setup cycle, so data stands through the access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit; // unmapped addresses error, writes dropped
  assign prdata  = prdata_q;

  // pin synchronisers
  sync2 #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({dev_j_to_k, dev_low_speed, dev_connect}),
    .q       ({jk_s, ls_s, conn_s})
  );

  // port command register; the write strobes one command with its own select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q    <= RST_HUB_PORT_COMMAND;
      cmd_go_q <= 1'b0;
    end else begin
      cmd_go_q <= wr_en && (idx == IDX_HUB_PORT_COMMAND) && pstrb[0];
      if (wr_en && (idx == IDX_HUB_PORT_COMMAND)) begin
        cmd_q <= merge(cmd_q, pwdata[7:0], PC_WMASK, pstrb[0]);
      end
    end
  end

  // hub power status: plain firmware storage, hub change bit is firmware's job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hps_q <= RST_HUB_POWER_STATUS;
    end else if (wr_en && (idx == IDX_HUB_POWER_STATUS)) begin
      hps_q <= merge(hps_q, pwdata[7:0], HS_WMASK, pstrb[0]);
    end
  end

  // global state writable bits; zero configuration value clears configured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwake_q  <= RST_HUB_GLOBAL_STATE[GS_RWAKE];
      config_q <= RST_HUB_GLOBAL_STATE[GS_CONFIG];
      addr_q   <= RST_HUB_GLOBAL_STATE[GS_ADDR];
    end else if (wr_en && (idx == IDX_HUB_GLOBAL_STATE) && pstrb[0]) begin
      rwake_q  <= pwdata[GS_RWAKE];
      config_q <= pwdata[GS_CONFIG];
      addr_q   <= pwdata[GS_ADDR];
    end
  end

  // resume indicator: set wins, clears when no port is still resuming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_ind_q <= 1'b0;
    end else if (upstream_resume) begin
      resume_ind_q <= 1'b1;
    end else if (resume_ind_q && (busy_w == 2'b00)) begin
      resume_ind_q <= 1'b0;
    end
  end

  // port 1 suspend tracked here since firmware owns its enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_susp_q <= 1'b0;
    end else if (cmd_go_q && (cmd_q[2:0] == SEL_PORT1)) begin
      unique case (cmd_q[6:4])
        CMD_SUSPEND: p1_susp_q <= 1'b1;
        CMD_RESUME,
        CMD_RESET:   p1_susp_q <= 1'b0;
        default:     p1_susp_q <= p1_susp_q;
      endcase
    end
  end

  // firmware owned port bits, power and overcurrent only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q <= 2'b00;
      oc_q    <= 2'b00;
    end else if (wr_en && pstrb[0]) begin
      if (idx == IDX_PORT2_STATUS) begin
        power_q[0] <= pwdata[PS_POWER];
        oc_q[0]    <= pwdata[PS_OC];
      end
      if (idx == IDX_PORT3_STATUS) begin
        power_q[1] <= pwdata[PS_POWER];
        oc_q[1]    <= pwdata[PS_OC];
      end
    end
  end

  // eof2 sampling of connect and speed; speed only with a device present
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_q      <= 2'b00;
      slow_q      <= 2'b00;
      conn_prev_q <= 2'b00;
    end else begin
      conn_prev_q <= conn_s;
      if (eof2_tick) begin
        conn_q <= conn_s;
        for (int i = 0; i < 2; i++) begin
          if (conn_s[i]) slow_q[i] <= ls_s[i];
        end
      end
    end
  end

  // per-port command pulses and engines for ports 2 and 3
  assign go_w[0] = cmd_go_q && (cmd_q[2:0] == SEL_PORT2);
  assign go_w[1] = cmd_go_q && (cmd_q[2:0] == SEL_PORT3);

  for (genvar g = 0; g < 2; g++) begin : g_port
    port_engine #(
      .RESUME_CYC (RESUME_CYC),
      .RESET_CYC  (RESET_CYC)
    ) u_eng (
      .pclk        (pclk),
      .presetn     (presetn),
      .cmd_go      (go_w[g]),
      .cmd         (cmd_q[6:4]),
      .wake_ok     (rwake_q),
      .wake_evt    ((conn_s[g] ^ conn_prev_q[g]) || jk_s[g]),
      .enabled_q   (en_w[g]),
      .suspended_q (susp_w[g]),
      .resetting   (rst_w[g]),
      .drive_k     (port_drive_k[g]),
      .drive_se0   (port_drive_se0[g]),
      .repeat_en   (port_repeat_en[g]),
      .resume_busy (busy_w[g])
    );
  end

  // function side controls
  assign func_reset      = cmd_go_q && (cmd_q[2:0] == SEL_PORT1) && (cmd_q[6:4] == CMD_RESET);
  assign func_respond_en = !p1_susp_q;
  assign hub_addr_enable = addr_q;

  // read mux, registered; upper bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (idx)
        IDX_HUB_PORT_COMMAND: prdata_q <= {24'h000000, cmd_q & PC_WMASK};
        IDX_HUB_POWER_STATUS: prdata_q <= {24'h000000, hps_q & HS_WMASK};
        IDX_HUB_GLOBAL_STATE: prdata_q <= {24'h000000, 3'b000, hub_suspended, resume_ind_q,
                                           rwake_q, config_q, addr_q};
        IDX_PORT1_STATUS:     prdata_q <= {24'h000000, pstat(1'b0, 1'b1, 1'b0, 1'b0,
                                           p1_susp_q, 1'b0, 1'b1)};
        IDX_PORT2_STATUS:     prdata_q <= {24'h000000, pstat(slow_q[0], power_q[0], rst_w[0], oc_q[0],
                                           susp_w[0], en_w[0], conn_q[0])};
        IDX_PORT3_STATUS:     prdata_q <= {24'h000000, pstat(slow_q[1], power_q[1], rst_w[1], oc_q[1],
                                           susp_w[1], en_w[1], conn_q[1])};
        default:              prdata_q <= 32'h0000_0000;
      endcase
    end
  end

endmodule : hub_port_control

// ==== hub_port_control_monitor.sv ====
// Purpose: concurrent checks on the hub port control ports
// Assumes: one pclk domain, presetn asynchronous active low
// Notes: timing checks watch the port 2 lane, the port 3 lane is alike
`timescale 1ns/10ps
module hub_port_control_monitor
  import hub_port_pkg::*;
#(
  parameter int RESUME_CYC = RESUME_K_CYC,
  parameter int RESET_CYC  = PORT_RESET_CYC
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // port and function outputs
  input wire logic [1:0]  port_drive_k,
  input wire logic [1:0]  port_drive_se0,
  input wire logic [1:0]  port_repeat_en,
  input wire logic        func_reset,
  input wire logic        func_respond_en,
  input wire logic        hub_addr_enable
);
  logic        acc_w;
  logic [15:0] idx;
  logic [31:0] k_cnt_q; // wide enough for the full 20 ms count

  // a write access that the register file will accept
  assign acc_w = psel && penable && pwrite && pstrb[0];
  assign idx   = paddr[17:2];

  // run length of resume K on port 2, judged when K ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) k_cnt_q <= 32'h0;
    else if (port_drive_k[0]) k_cnt_q <= k_cnt_q + 32'h1;
    else k_cnt_q <= 32'h0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_k_len;
    $fell(port_drive_k[0]) |-> k_cnt_q >= RESUME_CYC;
  endproperty
  a_k_len: assert property (p_k_len) else $error("resume K too short");
  property p_k_eop;
    $fell(port_drive_k[0]) |-> ##[0:1] port_drive_se0[0];
  endproperty
  a_k_eop: assert property (p_k_eop) else $error("no EOP after resume K");
  property p_se0_en;
    $fell(port_drive_se0[0]) |-> ##[0:2] port_repeat_en[0];
  endproperty
  a_se0_en: assert property (p_se0_en) else $error("port not enabled after SE0");
  property p_k_norep;
    port_drive_k[0] |-> !port_repeat_en[0];
  endproperty
  a_k_norep: assert property (p_k_norep) else $error("traffic repeated during K");
  property p_addr;
    $changed(hub_addr_enable) |-> $past(acc_w && idx == IDX_HUB_GLOBAL_STATE);
  endproperty
  a_addr: assert property (p_addr) else $error("address enable moved alone");
  property p_freset;
    acc_w && idx == IDX_HUB_PORT_COMMAND && pwdata[7:0] == 8'h21 |-> ##[1:3] func_reset;
  endproperty
  a_freset: assert property (p_freset) else $error("no function reset");
  property p_fpulse;
    func_reset |=> !func_reset;
  endproperty
  a_fpulse: assert property (p_fpulse) else $error("function reset too long");
  property p_resp;
    acc_w && idx == IDX_HUB_PORT_COMMAND && pwdata[7:0] == 8'h31 |-> ##[1:3] !func_respond_en;
  endproperty
  a_resp: assert property (p_resp) else $error("port 1 still answers");
  property p_rd8;
    psel && penable && !pwrite && idx == IDX_HUB_POWER_STATUS |-> prdata[31:4] == 28'h0;
  endproperty
  a_rd8: assert property (p_rd8) else $error("hub status upper bits set");

  c_resume: cover property ($fell(port_drive_k[0]));
  c_freset: cover property (func_reset);
  c_susp1: cover property ($fell(func_respond_en));
endmodule : hub_port_control_monitor

bind hub_port_control hub_port_control_monitor #(.RESUME_CYC(RESUME_CYC), .RESET_CYC(RESET_CYC)) u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .port_drive_k, .port_drive_se0, .port_repeat_en, .func_reset, .func_respond_en, .hub_addr_enable);

// ==== usb_dev_model.sv ====
// Purpose: downstream device model for ports 2 and 3
// Assumes: bench sets attach, speed and wake request per port
// Notes: empty ports fall to the pull-down level; wake is a short K burst
`timescale 1ns/10ps
module usb_dev_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench control, [0] port 2 and [1] port 3
  input  wire logic [1:0] attach,
  input  wire logic [1:0] low,
  input  wire logic [1:0] wake,
  // line levels toward the hub
  output logic      [1:0] dev_connect,
  output logic      [1:0] dev_low_speed,
  output logic      [1:0] dev_j_to_k
);
  logic [1:0] wake_q;
  logic [2:0] burst_q [2];

  // six cycles of K so the two-flop synchroniser cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q  <= 2'b00;
      burst_q <= '{3'h0, 3'h0};
    end else begin
      wake_q <= wake;
      for (int i = 0; i < 2; i++) begin
        if (wake[i] && !wake_q[i] && attach[i]) burst_q[i] <= 3'h6;
        else if (burst_q[i] != 3'h0) burst_q[i] <= burst_q[i] - 3'h1;
      end
    end
  end

  // pull-downs hold the lines of an empty port low
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      dev_connect[i]   = attach[i];
      dev_low_speed[i] = attach[i] & low[i];
      dev_j_to_k[i]    = burst_q[i] != 3'h0;
    end
  end
endmodule : usb_dev_model

// ==== usb_hub_port_control_tb.sv ====
// Purpose: self-checking bench for the hub port control block
// Assumes: zero-wait APB slave, shortened resume and reset counts
// Notes: register rows first, then sequences on ports 1 to 3
`timescale 1ns/10ps
`define CHK(nm, x, s) begin comparisons++; if ((s) !== (x)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, x, s); end end
module usb_hub_port_control_tb
  import hub_port_pkg::*;
;
  typedef struct {logic [15:0] idx; logic [7:0] wd; logic [7:0] ex; logic er;} row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, fr_seen;
  logic        hub_suspended, upstream_resume, eof2_tick, func_reset, func_respond_en, hub_addr_enable;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [1:0]  dev_connect, dev_low_speed, dev_j_to_k, attach, low, wake;
  logic [1:0]  port_drive_k, port_drive_se0, port_repeat_en;
  logic [7:0]  v;
  int          n_fail, comparisons;
  row_s        rows [7];

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  hub_port_control #(.RESUME_CYC(50), .RESET_CYC(30)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .hub_suspended, .upstream_resume, .eof2_tick, .dev_connect, .dev_low_speed, .dev_j_to_k,
    .port_drive_k, .port_drive_se0, .port_repeat_en, .func_reset, .func_respond_en, .hub_addr_enable);

  usb_dev_model u_dev (.pclk, .presetn, .attach, .low, .wake, .dev_connect, .dev_low_speed, .dev_j_to_k);

  // the function reset is a one-cycle pulse, so latch it
  always @(posedge pclk) begin
    if (!presetn) fr_seen <= 1'b0;
    else if (func_reset === 1'b1) fr_seen <= 1'b1;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++n > 20) begin n_fail++; tally_and_finish(); end
      @(posedge pclk);
    end
    v = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] i, input logic [7:0] x, input string nm);
    apb(1'b0, i, 8'h00, 4'h0);
    `CHK(nm, x, v)
  endtask : rd

  // a command needs two edges before status shows it
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, IDX_HUB_PORT_COMMAND, c, 4'h1);
    repeat (3) @(posedge pclk);
  endtask : cmd

  // bounded wait until the k lanes (sel 0) or the se0 lanes (sel 1) show x
  task automatic wait_eq(input logic sel, input logic [1:0] x);
    int n = 0;
    while ((sel ? port_drive_se0 : port_drive_k) !== x) begin
      if (++n > 400) begin n_fail++; tally_and_finish(); end
      @(posedge pclk);
    end
  endtask : wait_eq

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {hub_suspended, upstream_resume, eof2_tick, attach, low, wake} = '0;
    n_fail = 0;
    comparisons = 0;
    rows = '{'{IDX_HUB_POWER_STATUS, 8'hff, 8'h0f, 1'b0}, '{IDX_HUB_POWER_STATUS, 8'h0a, 8'h0a, 1'b0},
             '{IDX_HUB_POWER_STATUS, 8'h00, 8'h00, 1'b0}, '{IDX_HUB_GLOBAL_STATE, 8'hff, 8'h07, 1'b0},
             '{IDX_HUB_GLOBAL_STATE, 8'h00, 8'h00, 1'b0}, '{IDX_HUB_PORT_COMMAND, 8'h8f, 8'h07, 1'b0},
             '{16'h1fc6, 8'h5a, 8'h00, 1'b1}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_HUB_PORT_COMMAND, RST_HUB_PORT_COMMAND, "cmd_rst");
    rd(IDX_HUB_GLOBAL_STATE, RST_HUB_GLOBAL_STATE, "glb_rst");
    rd(IDX_PORT1_STATUS, 8'h21, "p1_stat");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd, 4'h1);
      rd(rows[i].idx, rows[i].ex, "row");
      `CHK("row_err", rows[i].er, e)
    end
    apb(1'b1, IDX_HUB_POWER_STATUS, 8'h0f, 4'he);
    rd(IDX_HUB_POWER_STATUS, 8'h00, "strb");
    apb(1'b1, IDX_HUB_GLOBAL_STATE, 8'h01, 4'h1);
    // the bit is launched at the access edge, so look one edge later
    @(posedge pclk);
    `CHK("addr_en", 1'b1, hub_addr_enable)
    hub_suspended <= 1'b1;
    apb(1'b1, IDX_HUB_GLOBAL_STATE, 8'h00, 4'h1);
    rd(IDX_HUB_GLOBAL_STATE, 8'h10, "susp");
    hub_suspended <= 1'b0;
    attach <= 2'b11;
    low    <= 2'b01;
    repeat (4) @(posedge pclk);
    rd(IDX_PORT2_STATUS, 8'h00, "pre_eof2");
    eof2_tick <= 1'b1;
    @(posedge pclk);
    eof2_tick <= 1'b0;
    rd(IDX_PORT2_STATUS, 8'h41, "p2_conn");
    rd(IDX_PORT3_STATUS, 8'h01, "p3_conn");
    cmd(8'h12);
    apb(1'b1, IDX_HUB_PORT_COMMAND, 8'h13, 4'h1);
    cmd(8'h03);
    rd(IDX_PORT2_STATUS, 8'h43, "p2_en");
    rd(IDX_PORT3_STATUS, 8'h01, "p3_dis");
    `CHK("rep", 2'b01, port_repeat_en)
    apb(1'b1, IDX_PORT2_STATUS, 8'hff, 4'h1);
    rd(IDX_PORT2_STATUS, 8'h6b, "p2_fw");
    apb(1'b1, IDX_PORT2_STATUS, 8'h00, 4'h1);
    cmd(8'h22);
    `CHK("se0", 2'b01, port_drive_se0)
    apb(1'b0, IDX_PORT2_STATUS, 8'h00, 4'h0);
    `CHK("p2_rst", 1'b1, v[PS_RESET])
    wait_eq(1'b1, 2'b00);
    repeat (3) @(posedge pclk);
    rd(IDX_PORT2_STATUS, 8'h43, "p2_rdone");
    cmd(8'h32);
    apb(1'b0, IDX_PORT2_STATUS, 8'h00, 4'h0);
    `CHK("p2_susp", 1'b1, v[PS_SUSP])
    `CHK("rep_susp", 1'b0, port_repeat_en[0])
    cmd(8'h42);
    `CHK("k", 2'b01, port_drive_k)
    upstream_resume <= 1'b1;
    @(posedge pclk);
    upstream_resume <= 1'b0;
    apb(1'b0, IDX_HUB_GLOBAL_STATE, 8'h00, 4'h0);
    `CHK("res_on", 1'b1, v[GS_RESUME])
    wait_eq(1'b0, 2'b00);
    wait_eq(1'b1, 2'b00);
    repeat (3) @(posedge pclk);
    rd(IDX_PORT2_STATUS, 8'h43, "p2_resumed");
    apb(1'b0, IDX_HUB_GLOBAL_STATE, 8'h00, 4'h0);
    `CHK("res_off", 1'b0, v[GS_RESUME])
    cmd(8'h43);
    `CHK("k_idle", 2'b00, port_drive_k)
    cmd(8'h13);
    cmd(8'h33);
    wake <= 2'b10;
    repeat (20) @(posedge pclk);
    wake <= 2'b00;
    apb(1'b0, IDX_PORT3_STATUS, 8'h00, 4'h0);
    `CHK("p3_nowake", 1'b1, v[PS_SUSP])
    apb(1'b1, IDX_HUB_GLOBAL_STATE, 8'h04, 4'h1);
    wake <= 2'b10;
    wait_eq(1'b0, 2'b10);
    wake <= 2'b00;
    wait_eq(1'b0, 2'b00);
    wait_eq(1'b1, 2'b00);
    repeat (3) @(posedge pclk);
    apb(1'b0, IDX_PORT3_STATUS, 8'h00, 4'h0);
    `CHK("p3_wake", 1'b0, v[PS_SUSP])
    cmd(8'h21);
    `CHK("freset", 1'b1, fr_seen)
    cmd(8'h31);
    `CHK("p1_susp", 1'b0, func_respond_en)
    cmd(8'h41);
    `CHK("p1_res", 1'b1, func_respond_en)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("rep_rst", 2'b00, port_repeat_en)
    rd(IDX_HUB_GLOBAL_STATE, 8'h00, "glb_rst2");
    tally_and_finish();
  end
endmodule : usb_hub_port_control_tb
